// >>> verilog/cct_timer.sv
/*
  cascadable compare timer: 16-bit up counter or two byte timers with compare,
  overflow and toggle outputs, reached over a plain byte register port.
  assumes one clock, synchronous active-low reset, event pin asynchronous.
*/
`timescale 1ns/1ps
module cct_timer
(
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire cct_pkg::cct_bus_req_t bus_req,
  output logic [7:0]                 rd_data,
  input  wire logic                  event_input_pin,
  output logic                       high_toggle_pin,
  output logic                       low_toggle_pin,
  output logic                       high_irq,
  output logic                       low_irq
);

  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    hit = (a == r);
  endfunction

  function automatic logic presc_tick(input logic [1:0] sel, input logic [4:0] p);
    case (sel)
      cct_pkg::DIV_32: presc_tick = &p[4:0];
      cct_pkg::DIV_16: presc_tick = &p[3:0];
      cct_pkg::DIV_4:  presc_tick = &p[1:0];
      default:         presc_tick = p[0];
    endcase
  endfunction

  logic [7:0]                   ctrl_r;
  logic [7:0]                   stat_r;
  logic [7:0]                   cnt_hi_r;
  logic [7:0]                   cnt_lo_r;
  logic [7:0]                   cmp_hi_r;
  logic [7:0]                   cmp_lo_r;
  logic [7:0]                   tmp_r;
  logic [1:0]                   req_r;
  logic [1:0]                   en_r;
  logic                         edge_rise_r;
  logic [cct_pkg::PRESC_W-1:0]  presc_r;
  logic                         ev_s1_r;
  logic                         ev_s2_r;
  logic                         ev_s3_r;
  logic                         eq_hi_r;
  logic                         eq_lo_r;
  logic                         eq16_r;

  //////////////////////////////////////////////////////////////////////////////
  // decode and events
  logic split;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_chi;
  logic wr_clo;
  logic wr_mhi;
  logic wr_mlo;
  logic rd_chi;
  logic ev_edge;
  logic lo_tick;
  logic hi_tick;
  logic lo_wrap;
  logic hi_wrap;
  logic eq_hi;
  logic eq_lo;
  logic eq16;
  logic match_hi;
  logic match_lo;
  logic clr_hi;
  logic clr_lo;
  logic set_hi_ovf;
  logic set_lo_ovf;
  logic set_hi_req;
  logic set_lo_req;

  assign split   = ctrl_r[cct_pkg::CTRL_SPLIT];
  assign wr_ctrl = bus_req.wr && hit(bus_req.addr, cct_pkg::ADDR_CTRL);
  assign wr_stat = bus_req.wr && hit(bus_req.addr, cct_pkg::ADDR_STATUS);
  assign wr_chi  = bus_req.wr && hit(bus_req.addr, cct_pkg::ADDR_CNT_HI);
  assign wr_clo  = bus_req.wr && hit(bus_req.addr, cct_pkg::ADDR_CNT_LO);
  assign wr_mhi  = bus_req.wr && hit(bus_req.addr, cct_pkg::ADDR_CMP_HI);
  assign wr_mlo  = bus_req.wr && hit(bus_req.addr, cct_pkg::ADDR_CMP_LO);
  assign rd_chi  = bus_req.rd && hit(bus_req.addr, cct_pkg::ADDR_CNT_HI);

  // one chosen edge of the synchronised event pin
  assign ev_edge = edge_rise_r ? (ev_s2_r && !ev_s3_r) : (!ev_s2_r && ev_s3_r);

  // low source: event pin or prescaler, same field in both modes
  assign lo_tick = ctrl_r[cct_pkg::CTRL_LO_SRC]
                   ? presc_tick(ctrl_r[cct_pkg::CTRL_LO_SEL +: 2], presc_r)
                   : ev_edge;
  assign lo_wrap = lo_tick && (cnt_lo_r == cct_pkg::BYTE_MAX);
  // high source: own prescaler choice when split, low carry otherwise
  assign hi_tick = split ? presc_tick(ctrl_r[cct_pkg::CTRL_HI_SEL +: 2], presc_r)
                         : lo_wrap;
  assign hi_wrap = hi_tick && (cnt_hi_r == cct_pkg::BYTE_MAX);

  assign eq_hi    = (cnt_hi_r == cmp_hi_r);
  assign eq_lo    = (cnt_lo_r == cmp_lo_r);
  assign eq16     = eq_hi && eq_lo;
  // a match is counted once, when equality begins
  assign match_hi = split ? (eq_hi && !eq_hi_r) : (eq16 && !eq16_r);
  assign match_lo = split && eq_lo && !eq_lo_r;

  assign clr_hi = match_hi && stat_r[cct_pkg::ST_HI_CLR];
  assign clr_lo = split ? (match_lo && stat_r[cct_pkg::ST_LO_CLR]) : clr_hi;

  assign set_hi_ovf = hi_wrap;
  assign set_lo_ovf = split && lo_wrap;
  assign set_hi_req = (hi_wrap && stat_r[cct_pkg::ST_HI_OVIE]) || match_hi;
  assign set_lo_req = split && ((lo_wrap && stat_r[cct_pkg::ST_LO_OVIE]) || match_lo);

  //////////////////////////////////////////////////////////////////////////////
  // prescaler and event synchroniser
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      presc_r <= '0;
    else
      presc_r <= presc_r + 5'h01;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      ev_s1_r <= 1'b0;
      ev_s2_r <= 1'b0;
      ev_s3_r <= 1'b0;
    end
    else
    begin
      ev_s1_r <= event_input_pin;
      ev_s2_r <= ev_s1_r;
      ev_s3_r <= ev_s2_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control and configuration
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      ctrl_r      <= cct_pkg::CTRL_RST;
      en_r        <= 2'h0;
      edge_rise_r <= 1'b1;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= bus_req.wdata;
      if (bus_req.wr && hit(bus_req.addr, cct_pkg::ADDR_IRQ_EN))
        en_r <= bus_req.wdata[1:0];
      if (bus_req.wr && hit(bus_req.addr, cct_pkg::ADDR_EDGE_CFG))
        edge_rise_r <= bus_req.wdata[0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status flags: hardware set wins over a software zero write
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      stat_r <= cct_pkg::STAT_RST;
    else
    begin
      if (wr_stat)
      begin
        stat_r[cct_pkg::ST_HI_OVIE] <= bus_req.wdata[cct_pkg::ST_HI_OVIE];
        stat_r[cct_pkg::ST_HI_CLR]  <= bus_req.wdata[cct_pkg::ST_HI_CLR];
        stat_r[cct_pkg::ST_LO_OVIE] <= bus_req.wdata[cct_pkg::ST_LO_OVIE];
        stat_r[cct_pkg::ST_LO_CLR]  <= bus_req.wdata[cct_pkg::ST_LO_CLR];
      end
      stat_r[cct_pkg::ST_HI_OVF] <= set_hi_ovf || (stat_r[cct_pkg::ST_HI_OVF]
        && !(wr_stat && !bus_req.wdata[cct_pkg::ST_HI_OVF]));
      stat_r[cct_pkg::ST_HI_MATCH] <= match_hi || (stat_r[cct_pkg::ST_HI_MATCH]
        && !(wr_stat && !bus_req.wdata[cct_pkg::ST_HI_MATCH]));
      stat_r[cct_pkg::ST_LO_OVF] <= set_lo_ovf || (stat_r[cct_pkg::ST_LO_OVF]
        && !(wr_stat && !bus_req.wdata[cct_pkg::ST_LO_OVF]));
      stat_r[cct_pkg::ST_LO_MATCH] <= match_lo || (stat_r[cct_pkg::ST_LO_MATCH]
        && !(wr_stat && !bus_req.wdata[cct_pkg::ST_LO_MATCH]));
    end
  end

  // interrupt requests, cleared by writing zero
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      req_r <= 2'h0;
    else
    begin
      req_r[cct_pkg::IRQ_HI] <= set_hi_req || (req_r[cct_pkg::IRQ_HI] && !(bus_req.wr
        && hit(bus_req.addr, cct_pkg::ADDR_IRQ_REQ) && !bus_req.wdata[cct_pkg::IRQ_HI]));
      req_r[cct_pkg::IRQ_LO] <= set_lo_req || (req_r[cct_pkg::IRQ_LO] && !(bus_req.wr
        && hit(bus_req.addr, cct_pkg::ADDR_IRQ_REQ) && !bus_req.wdata[cct_pkg::IRQ_LO]));
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      high_irq <= 1'b0;
      low_irq  <= 1'b0;
    end
    else
    begin
      high_irq <= req_r[cct_pkg::IRQ_HI] && en_r[cct_pkg::IRQ_HI];
      low_irq  <= req_r[cct_pkg::IRQ_LO] && en_r[cct_pkg::IRQ_LO];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // temporary byte for 16-bit transfers
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      tmp_r <= 8'h00;
    else if (!split)
    begin
      if (wr_chi || wr_mhi)
        tmp_r <= bus_req.wdata;
      else if (rd_chi)
        tmp_r <= cnt_lo_r;
      else if (bus_req.rd && hit(bus_req.addr, cct_pkg::ADDR_CMP_HI))
        tmp_r <= cmp_lo_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // counters: cpu write, then clear on match, then count
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      cnt_lo_r <= cct_pkg::CNT_RST;
    else if (wr_clo)
      cnt_lo_r <= bus_req.wdata;
    else if (clr_lo)
      cnt_lo_r <= 8'h00;
    else if (lo_tick)
      cnt_lo_r <= cnt_lo_r + 8'h01;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      cnt_hi_r <= cct_pkg::CNT_RST;
    else if (split && wr_chi)
      cnt_hi_r <= bus_req.wdata;
    else if (!split && wr_clo)
      cnt_hi_r <= tmp_r;
    else if (clr_hi)
      cnt_hi_r <= 8'h00;
    else if (hi_tick)
      cnt_hi_r <= cnt_hi_r + 8'h01;
  end

  // low compare byte: direct in both modes
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      cmp_lo_r <= cct_pkg::CMP_RST;
    else if (wr_mlo)
      cmp_lo_r <= bus_req.wdata;
  end

  // high compare byte: direct when split, from the temporary byte otherwise
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      cmp_hi_r <= cct_pkg::CMP_RST;
    else if (split && wr_mhi)
      cmp_hi_r <= bus_req.wdata;
    else if (!split && wr_mlo)
      cmp_hi_r <= tmp_r;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      eq_hi_r <= 1'b0;
      eq_lo_r <= 1'b0;
      eq16_r  <= 1'b0;
    end
    else
    begin
      eq_hi_r <= eq_hi;
      eq_lo_r <= eq_lo;
      eq16_r  <= eq16;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // toggle pins: a level write overrides a match in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      high_toggle_pin <= 1'b0;
    else if (wr_ctrl)
      high_toggle_pin <= bus_req.wdata[cct_pkg::CTRL_HI_LEVEL];
    else if (match_hi)
      high_toggle_pin <= !high_toggle_pin;
  end

  // low pin toggles only in byte mode, since match_lo is gated by split
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      low_toggle_pin <= 1'b0;
    else if (wr_ctrl)
      low_toggle_pin <= bus_req.wdata[cct_pkg::CTRL_LO_LEVEL];
    else if (match_lo)
      low_toggle_pin <= !low_toggle_pin;
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data, valid only in the cycle after the read strobe
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      rd_data <= 8'h00;
    else if (!bus_req.rd)
      rd_data <= 8'h00;
    else if (hit(bus_req.addr, cct_pkg::ADDR_CTRL))
      rd_data <= cct_pkg::RD_CTRL;
    else if (hit(bus_req.addr, cct_pkg::ADDR_STATUS))
      rd_data <= stat_r;
    else if (hit(bus_req.addr, cct_pkg::ADDR_CNT_HI))
      rd_data <= cnt_hi_r;
    else if (hit(bus_req.addr, cct_pkg::ADDR_CNT_LO))
      rd_data <= split ? cnt_lo_r : tmp_r;
    else if (hit(bus_req.addr, cct_pkg::ADDR_CMP_HI))
      rd_data <= cmp_hi_r;
    else if (hit(bus_req.addr, cct_pkg::ADDR_CMP_LO))
      rd_data <= split ? cmp_lo_r : tmp_r;
    else if (hit(bus_req.addr, cct_pkg::ADDR_IRQ_REQ))
      rd_data <= {6'h00, req_r};
    else if (hit(bus_req.addr, cct_pkg::ADDR_IRQ_EN))
      rd_data <= {6'h00, en_r};
    else if (hit(bus_req.addr, cct_pkg::ADDR_EDGE_CFG))
      rd_data <= {7'h00, edge_rise_r};
    else
      rd_data <= cct_pkg::RD_UNMAP;
  end

endmodule // cct_timer

// >>> verilog/cct_pkg.sv
/*
  constants, register map and bus carrier of the cascadable compare timer.
  assumes a byte-wide register port on sys_clk with read data one cycle after the strobe.
*/
// Operation
// - counter is two cascaded bytes, high byte bits 15..8, low byte bits 7..0.
// - split select bit 0 gives one 16-bit timer; high byte counts low overflows.
// - in 16-bit mode only the low clock-select field picks the counter clock.
// - split select bit 1 gives two byte counters, each with its own clock select.
// - clock selects offer clock divided by 32, 16, 4, 2; low also external events.
// - 16-bit wrap from all ones to zero sets the high overflow flag.
// - 16-bit overflow with its enable sets high request; interrupt needs high enable.
// - byte mode wrap 0xFF to 0x00 sets that counter's overflow flag.
// - byte mode overflow sets request only if enabled; interrupt needs that counter's enable.
// - 16-bit match sets high match flag and high request; interrupt if enabled.
// - 16-bit mode clears the counter on match only with high clear select.
// - byte mode clears each counter on its own match with its own clear select.
// - high match toggles high pin; high output-level bit forces its level.
// - byte mode low match toggles the low pin.
// - 16-bit mode counter and compare transfers go through a temporary byte.
// - reset clears both byte counters.
// - reset sets both byte compare registers to all ones.
// - control, status, two counters, two compares sit at consecutive byte addresses.
// - writing an output-level bit drives that pin to the level at once.
// - software clears a status flag by writing 0; writing 1 does nothing.
package cct_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // register map
  localparam logic [15:0] ADDR_CTRL      = 16'hFFB6;
  localparam logic [15:0] ADDR_STATUS    = 16'hFFB7;
  localparam logic [15:0] ADDR_CNT_HI    = 16'hFFB8;
  localparam logic [15:0] ADDR_CNT_LO    = 16'hFFB9;
  localparam logic [15:0] ADDR_CMP_HI    = 16'hFFBA;
  localparam logic [15:0] ADDR_CMP_LO    = 16'hFFBB;
  localparam logic [15:0] ADDR_IRQ_REQ   = 16'hFFBC;
  localparam logic [15:0] ADDR_IRQ_EN    = 16'hFFBD;
  localparam logic [15:0] ADDR_EDGE_CFG  = 16'hFFBE;

  // reset values, fixed read values and byte maximum
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] STAT_RST  = 8'h00;
  localparam logic [7:0] CNT_RST   = 8'h00;
  localparam logic [7:0] CMP_RST   = 8'hFF;
  localparam logic [7:0] RD_CTRL   = 8'hFF;
  localparam logic [7:0] RD_UNMAP  = 8'h00;
  localparam logic [7:0] BYTE_MAX  = 8'hFF;

  // control fields
  localparam int CTRL_HI_LEVEL = 7;
  localparam int CTRL_SPLIT    = 6;
  localparam int CTRL_HI_SEL   = 4;
  localparam int CTRL_LO_LEVEL = 3;
  localparam int CTRL_LO_SRC   = 2;
  localparam int CTRL_LO_SEL   = 0;

  // status fields
  localparam int ST_HI_OVF   = 7;
  localparam int ST_HI_MATCH = 6;
  localparam int ST_HI_OVIE  = 5;
  localparam int ST_HI_CLR   = 4;
  localparam int ST_LO_OVF   = 3;
  localparam int ST_LO_MATCH = 2;
  localparam int ST_LO_OVIE  = 1;
  localparam int ST_LO_CLR   = 0;

  // request / enable fields
  localparam int IRQ_HI = 1;
  localparam int IRQ_LO = 0;

  // prescaler divide selects
  localparam logic [1:0] DIV_32 = 2'h0;
  localparam logic [1:0] DIV_16 = 2'h1;
  localparam logic [1:0] DIV_4  = 2'h2;
  localparam logic [1:0] DIV_2  = 2'h3;
  localparam int PRESC_W = 5;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } cct_bus_req_t;

endpackage

// >>> dv/cct_timer_chk.sv
/*
  port checker of the cascadable compare timer: read port, pin levels, irq gating.
  assumes one clock sys_clk and synchronous active-low resetn, bound to the top module.
*/
`timescale 1ns/1ps
module cct_timer_chk
(
  input wire logic                  sys_clk,
  input wire logic                  resetn,
  input wire cct_pkg::cct_bus_req_t bus_req,
  input wire logic [7:0]            rd_data,
  input wire logic                  high_toggle_pin,
  input wire logic                  low_toggle_pin,
  input wire logic                  high_irq,
  input wire logic                  low_irq
);
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  wire logic ctrl_wr = bus_req.wr && (bus_req.addr == cct_pkg::ADDR_CTRL);
  wire logic en_wr   = bus_req.wr && (bus_req.addr == cct_pkg::ADDR_IRQ_EN);

  ////////////////////////////////////////////////////////////////////////////////
  AST_RD_IDLE: assert property (!bus_req.rd |=> rd_data == 8'h00)
    else $error("read data not zero outside a read answer");
  AST_CTRL_WO: assert property (bus_req.rd && bus_req.addr == cct_pkg::ADDR_CTRL
    |=> rd_data == 8'hFF) else $error("control register read not all ones");
  AST_UNMAPPED: assert property (bus_req.rd && (bus_req.addr < cct_pkg::ADDR_CTRL
    || bus_req.addr > cct_pkg::ADDR_EDGE_CFG) |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  AST_HI_LEVEL: assert property (ctrl_wr |=> high_toggle_pin == $past(bus_req.wdata[7]))
    else $error("high pin does not follow written level");
  AST_LO_LEVEL: assert property (ctrl_wr |=> low_toggle_pin == $past(bus_req.wdata[3]))
    else $error("low pin does not follow written level");
  AST_HI_IRQ_OFF: assert property (en_wr && !bus_req.wdata[1] |=> ##1 !high_irq)
    else $error("high irq stays up with its enable cleared");
  AST_LO_IRQ_OFF: assert property (en_wr && !bus_req.wdata[0] |-> ##2 !low_irq)
    else $error("low irq stays up with its enable cleared");
  AST_HI_TOGGLE_ONCE: assert property ($changed(high_toggle_pin) && !$past(bus_req.wr)
    |=> $stable(high_toggle_pin) || $past(bus_req.wr) || $past(bus_req.wr, 2))
    else $error("high pin toggled twice for one match");

  COV_HI_TOGGLE: cover property ($changed(high_toggle_pin) && !$past(bus_req.wr));
  COV_HI_IRQ: cover property ($rose(high_irq));
  COV_LO_IRQ: cover property ($rose(low_irq));
endmodule // cct_timer_chk

// >>> dv/test_cascadable_compare_timer.sv
/*
  self-checking bench of the cascadable compare timer, one task a scenario.
  assumes the checker module cct_timer_chk, bound at the foot of this file.
*/
`timescale 1ns/1ps
module test_cascadable_compare_timer;
  logic                  sys_clk;
  logic                  resetn;
  logic                  event_input_pin;
  cct_pkg::cct_bus_req_t bus_req;
  logic [7:0]            rd_data;
  logic                  high_toggle_pin;
  logic                  low_toggle_pin;
  logic                  high_irq;
  logic                  low_irq;
  int                    miscompares;
  int                    tests_run;
  int                    cycles;

  cct_timer dut_u
  (
    .sys_clk         (sys_clk),
    .resetn          (resetn),
    .bus_req         (bus_req),
    .rd_data         (rd_data),
    .event_input_pin (event_input_pin),
    .high_toggle_pin (high_toggle_pin),
    .low_toggle_pin  (low_toggle_pin),
    .high_irq        (high_irq),
    .low_irq         (low_irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1;
    chk(what, exp, rd_data);
  endtask

  // rising edges, held long enough for the synchroniser
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      event_input_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      event_input_pin <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
  endtask

  task automatic wait_hi(input logic lvl, input int lim, input string what);
    int k = 0;
    while (high_toggle_pin !== lvl && k < lim)
    begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    chk(what, {7'h00, lvl}, {7'h00, high_toggle_pin});
  endtask

  task automatic settle2;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_vals;
    rd(cct_pkg::ADDR_CTRL, 8'hFF, "control");
    rd(cct_pkg::ADDR_STATUS, 8'h00, "status");
    rd(cct_pkg::ADDR_CNT_HI, 8'h00, "cnt hi");
    rd(cct_pkg::ADDR_CNT_LO, 8'h00, "cnt lo");
    rd(cct_pkg::ADDR_CMP_HI, 8'hFF, "cmp hi");
    rd(cct_pkg::ADDR_CMP_LO, 8'hFF, "cmp lo");
    rd(16'hFFC0, 8'h00, "unmapped");
  endtask

  task automatic t_level;
    wr(cct_pkg::ADDR_CTRL, 8'h88);
    #1;
    chk("hi level", 8'h01, {7'h00, high_toggle_pin});
    chk("lo level", 8'h01, {7'h00, low_toggle_pin});
    wr(cct_pkg::ADDR_CTRL, 8'h00);
    #1;
    chk("hi low", 8'h00, {7'h00, high_toggle_pin});
  endtask

  task automatic t_temp_events;
    wr(cct_pkg::ADDR_CNT_HI, 8'h12);
    wr(cct_pkg::ADDR_CNT_LO, 8'h34);
    rd(cct_pkg::ADDR_CNT_HI, 8'h12, "pair hi");
    rd(cct_pkg::ADDR_CNT_LO, 8'h34, "pair lo");
    wr(cct_pkg::ADDR_CNT_HI, 8'hAB);
    rd(cct_pkg::ADDR_CNT_HI, 8'h12, "lone hi");
    wr(cct_pkg::ADDR_CNT_HI, 8'h12);
    wr(cct_pkg::ADDR_CNT_LO, 8'hFE);
    pulse(3);
    rd(cct_pkg::ADDR_CNT_HI, 8'h13, "carry hi");
    rd(cct_pkg::ADDR_CNT_LO, 8'h01, "event lo");
  endtask

  task automatic t_match16;
    wr(cct_pkg::ADDR_CNT_HI, 8'h00);
    wr(cct_pkg::ADDR_CNT_LO, 8'h00);
    wr(cct_pkg::ADDR_CMP_HI, 8'h00);
    wr(cct_pkg::ADDR_CMP_LO, 8'h10);
    wr(cct_pkg::ADDR_STATUS, 8'h10);
    wr(cct_pkg::ADDR_CTRL, 8'h07);
    wait_hi(1'b1, 200, "first match");
    wait_hi(1'b0, 60, "match after clear");
    wr(cct_pkg::ADDR_CTRL, 8'h00);
    rd(cct_pkg::ADDR_STATUS, 8'h50, "match flag");
    rd(cct_pkg::ADDR_IRQ_REQ, 8'h02, "hi req");
    wr(cct_pkg::ADDR_IRQ_EN, 8'h02);
    settle2();
    chk("hi irq", 8'h01, {7'h00, high_irq});
    wr(cct_pkg::ADDR_STATUS, 8'hF0);
    rd(cct_pkg::ADDR_STATUS, 8'h70, "flag w1");
    wr(cct_pkg::ADDR_STATUS, 8'h30);
    rd(cct_pkg::ADDR_STATUS, 8'h30, "flag w0");
    wr(cct_pkg::ADDR_IRQ_REQ, 8'h00);
    settle2();
    chk("hi irq off", 8'h00, {7'h00, high_irq});
  endtask

  task automatic t_byte;
    wr(cct_pkg::ADDR_CTRL, 8'h70);
    wr(cct_pkg::ADDR_STATUS, 8'h22);
    wr(cct_pkg::ADDR_CNT_HI, 8'hFE);
    wr(cct_pkg::ADDR_CNT_LO, 8'hFF);
    wr(cct_pkg::ADDR_CMP_LO, 8'h01);
    pulse(2);
    rd(cct_pkg::ADDR_STATUS, 8'hEE, "byte flags");
    chk("lo toggle", 8'h01, {7'h00, low_toggle_pin});
    rd(cct_pkg::ADDR_IRQ_REQ, 8'h03, "both req");
    wr(cct_pkg::ADDR_IRQ_EN, 8'h01);
    settle2();
    chk("lo irq", 8'h01, {7'h00, low_irq});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      $display("[FAIL] run length expected 20000 seen %0d", cycles);
      results();
    end
  end

  initial
  begin
    resetn = 1'b0;
    event_input_pin = 1'b0;
    bus_req = '0;
    miscompares = 0;
    tests_run = 0;
    cycles = 0;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset_vals();
    t_level();
    t_temp_events();
    t_match16();
    t_byte();
    results();
  end
endmodule // test_cascadable_compare_timer

bind cct_timer cct_timer_chk chk_u
(
  .sys_clk         (sys_clk),
  .resetn          (resetn),
  .bus_req         (bus_req),
  .rd_data         (rd_data),
  .high_toggle_pin (high_toggle_pin),
  .low_toggle_pin  (low_toggle_pin),
  .high_irq        (high_irq),
  .low_irq         (low_irq)
);
